/* prc_defs.svh */
// Purpose: constants of the privilege checker and reset translation config
// Assumes: 32-bit register words, byte addressed Avalon-MM slave
// Notes: bit positions are little-endian indices (bit 31 of the word is msb)
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

`define PRC_ADDR_W 8
`define PRC_OFS_RESET_CFG 8'h00
`define PRC_OFS_STATUS 8'h04
`define PRC_OFS_MASK 8'h08
`define PRC_OFS_COUNT 8'h0c

// reset translation config layout, msb-0 bits 16..19, 24, 28..31
`define PRC_CFG_UATTR_HI 15
`define PRC_CFG_UATTR_LO 12
`define PRC_CFG_ENDIAN 7
`define PRC_CFG_EXTENDED_REAL_PAGE_HI 3
`define PRC_CFG_EXTENDED_REAL_PAGE_LO 0
`define PRC_CFG_RESERVED_VAL 32'h0000_0000

// status / mask layout
`define PRC_EV_PRIV 0
`define PRC_EV_ILLEGAL 1
`define PRC_EV_GUARD 2
`define PRC_EV_FETCH 3
`define PRC_EV_W 4
`define PRC_STATUS_RST 4'h0
`define PRC_MASK_RST 4'h0

// msb-0 bit 5 of the 10-bit register number is index 4
`define PRC_SPECIAL_REG_NUMBER_PRIV_BIT 4
`define PRC_SPECIAL_REG_NUMBER_W 10
`define PRC_SPR_FXE 10'h001
`define PRC_SPR_LINK 10'h008
`define PRC_SPR_COUNT 10'h009
`define PRC_SPR_UGEN 10'h100
`define PRC_SPR_UPGEN_LO 10'h104
`define PRC_SPR_UPGEN_HI 10'h107
`define PRC_SPR_TB_LO 10'h10c
`define PRC_SPR_TB_HI 10'h10d
`define PRC_SPR_RESET_CFG 10'h39b

// strap settle cycles after reset release
`define PRC_STRAP_WAIT 2'h3

`endif

/* prc_pkg.sv */
// Purpose: types of the privilege checker
// Assumes: used as prc_pkg::name, never imported
// Notes: operation classes come from core decode
package prc_pkg;

  typedef enum logic [4:0] {
    PRC_OP_PLAIN = 5'h00,
    PRC_OP_DC_BLK_INV = 5'h01,
    PRC_OP_DC_CC_INV = 5'h02,
    PRC_OP_DC_READ = 5'h03,
    PRC_OP_IC_CC_INV = 5'h04,
    PRC_OP_IC_READ = 5'h05,
    PRC_OP_FROM_DCR = 5'h06,
    PRC_OP_FROM_MSTATE = 5'h07,
    PRC_OP_TO_DCR = 5'h08,
    PRC_OP_TO_MSTATE = 5'h09,
    PRC_OP_RET_CRIT = 5'h0a,
    PRC_OP_RET_INT = 5'h0b,
    PRC_OP_RET_MCHK = 5'h0c,
    PRC_OP_TLB_READ = 5'h0d,
    PRC_OP_TLB_SEARCH = 5'h0e,
    PRC_OP_TLB_SYNC = 5'h0f,
    PRC_OP_TLB_WRITE = 5'h10,
    PRC_OP_EXT_EN_REG = 5'h11,
    PRC_OP_EXT_EN_IMM = 5'h12,
    PRC_OP_FROM_SPR = 5'h13,
    PRC_OP_TO_SPR = 5'h14
  } prc_op_t;

  typedef struct packed {
    logic valid;
    logic problem_state_bit;
    prc_op_t op;
    logic [9:0] special_reg_number;
  } prc_chk_req_t;

  typedef struct packed {
    logic valid;
    logic allowed;
    logic priv_exc;
    logic illegal_exc;
  } prc_chk_rsp_t;

  typedef struct packed {
    logic valid;
    logic is_fetch;
    logic speculative;
    logic guarded;
    logic exec_ok;
  } prc_spec_req_t;

  typedef struct packed {
    logic valid;
    logic go;
    logic hold;
  } prc_spec_rsp_t;

  typedef struct packed {
    logic [3:0] user_attr;
    logic little_endian;
    logic [3:0] extended_real_page;
  } prc_strap_t;

  typedef enum logic [2:0] {
    PRC_ST_WAIT = 3'b001,
    PRC_ST_CAPTURE = 3'b010,
    PRC_ST_DONE = 3'b100
  } prc_cap_state_t;

endpackage

/* prc_privilege_check.sv */
// Purpose: user/supervisor privilege check, speculative access gate, reset config register
// Assumes: decode requests are on mclk_i; straps come from pins and are synchronised
// Notes: Avalon-MM slave answers every access with waitrequest low one cycle after request
//
// Overview of operation
// [RULE_01] read-only register reports reset translation fields
// [RULE_02] reset config register access is privileged
// [RULE_03] bits 16-19 report four user attributes
// [RULE_04] bit 24 reports page endianness
// [RULE_05] bits 28-31 hold extended real page
// [RULE_06] problem bit 0: supervisor, everything allowed
// [RULE_07] problem bit 1: only non-privileged allowed
// [RULE_08] user privileged access raises privileged exception
// [RULE_09] listed cache, tlb, return, move ops privileged
// [RULE_10] special moves privileged when number bit 5 set
// [RULE_11] few special registers open to user mode
// [RULE_12] any number with bit 5 is privileged
// [RULE_13] user undefined number, bit 5 clear: illegal
// [RULE_14] supervisor must avoid undefined special numbers
// [RULE_15] speculative fetch along predicted path allowed
// [RULE_16] speculative out-of-order loads allowed
// [RULE_17] no speculative data access to guarded pages
// [RULE_18] no speculative fetch without execute permission
// [RULE_19] reserved config bits read zero, ignore writes
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "prc_defs.svh"

module prc_privilege_check #(
  parameter logic [9:0] SPR_FXE = `PRC_SPR_FXE,
  parameter logic [9:0] SPR_LINK = `PRC_SPR_LINK,
  parameter logic [9:0] SPR_COUNT = `PRC_SPR_COUNT,
  parameter logic [9:0] SPR_UGEN = `PRC_SPR_UGEN,
  parameter logic [9:0] SPR_UPGEN_LO = `PRC_SPR_UPGEN_LO,
  parameter logic [9:0] SPR_UPGEN_HI = `PRC_SPR_UPGEN_HI,
  parameter logic [9:0] SPR_TB_LO = `PRC_SPR_TB_LO,
  parameter logic [9:0] SPR_TB_HI = `PRC_SPR_TB_HI,
  parameter logic [9:0] SPR_RESET_CFG = `PRC_SPR_RESET_CFG
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  // straps from pins
  input wire logic [3:0] strap_user_attr_i,
  input wire logic strap_little_endian_i,
  input wire logic [3:0] strap_extended_real_page_i,
  // decode check
  input wire prc_pkg::prc_chk_req_t chk_req_i,
  output prc_pkg::prc_chk_rsp_t chk_rsp_o,
  output logic [31:0] spr_rdata_o,
  // speculative access gate
  input wire prc_pkg::prc_spec_req_t spec_req_i,
  output prc_pkg::prc_spec_rsp_t spec_rsp_o,
  // Avalon-MM slave
  input wire logic [`PRC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);

  // strap synchronisers, three stages
  prc_pkg::prc_strap_t strap_raw;
  prc_pkg::prc_strap_t sync1_q;
  prc_pkg::prc_strap_t sync2_q;
  prc_pkg::prc_strap_t sync3_q;
  prc_pkg::prc_strap_t cfg_q;
  prc_pkg::prc_cap_state_t cap_state_q;
  logic [1:0] cap_wait_q;
  logic [31:0] cfg_word;

  assign strap_raw.user_attr = strap_user_attr_i;
  assign strap_raw.little_endian = strap_little_endian_i;
  assign strap_raw.extended_real_page = strap_extended_real_page_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= strap_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // capture straps once after reset release, when stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cap_state_q <= prc_pkg::PRC_ST_WAIT;
      cap_wait_q <= 2'h0;
      cfg_q <= '0;
    end else begin
      case (cap_state_q)
        prc_pkg::PRC_ST_WAIT: begin
          cap_wait_q <= cap_wait_q + 2'h1;
          if (cap_wait_q == `PRC_STRAP_WAIT) begin
            cap_state_q <= prc_pkg::PRC_ST_CAPTURE;
          end
        end
        prc_pkg::PRC_ST_CAPTURE: begin
          if (sync2_q == sync3_q) begin
            cfg_q <= sync3_q; // see [RULE_01]
            cap_state_q <= prc_pkg::PRC_ST_DONE;
          end
        end
        prc_pkg::PRC_ST_DONE: begin
          cap_state_q <= prc_pkg::PRC_ST_DONE;
        end
        default: begin
          cap_state_q <= prc_pkg::PRC_ST_WAIT;
        end
      endcase
    end
  end

  // register image; no write path exists, reserved bits stay zero
  always_comb begin
    cfg_word = `PRC_CFG_RESERVED_VAL; // see [RULE_19]
    cfg_word[`PRC_CFG_UATTR_HI:`PRC_CFG_UATTR_LO] = cfg_q.user_attr; // see [RULE_03]
    cfg_word[`PRC_CFG_ENDIAN] = cfg_q.little_endian; // see [RULE_04]
    cfg_word[`PRC_CFG_EXTENDED_REAL_PAGE_HI:`PRC_CFG_EXTENDED_REAL_PAGE_LO] = cfg_q.extended_real_page; // see [RULE_05]
  end

  // privilege decode
  logic spr_move;
  logic spr_is_read;
  logic spr_bit5;
  logic spr_user_rw;
  logic spr_user_ro;
  logic spr_defined;
  logic op_privileged;
  logic user_mode;
  logic need_priv;
  logic need_illegal;

  assign spr_move = (chk_req_i.op == prc_pkg::PRC_OP_FROM_SPR) ||
                    (chk_req_i.op == prc_pkg::PRC_OP_TO_SPR);
  assign spr_is_read = (chk_req_i.op == prc_pkg::PRC_OP_FROM_SPR);
  assign spr_bit5 = chk_req_i.special_reg_number[`PRC_SPECIAL_REG_NUMBER_PRIV_BIT];
  // registers open to user mode in both directions
  assign spr_user_rw = (chk_req_i.special_reg_number == SPR_FXE) ||
                       (chk_req_i.special_reg_number == SPR_LINK) ||
                       (chk_req_i.special_reg_number == SPR_COUNT) ||
                       (chk_req_i.special_reg_number == SPR_UGEN);
  // registers open to user mode for reads only
  assign spr_user_ro = ((chk_req_i.special_reg_number >= SPR_UPGEN_LO) &&
                        (chk_req_i.special_reg_number <= SPR_UPGEN_HI)) ||
                       (chk_req_i.special_reg_number == SPR_TB_LO) ||
                       (chk_req_i.special_reg_number == SPR_TB_HI);
  assign spr_defined = spr_user_rw || spr_user_ro;

  always_comb begin
    case (chk_req_i.op)
      prc_pkg::PRC_OP_DC_BLK_INV,
      prc_pkg::PRC_OP_DC_CC_INV,
      prc_pkg::PRC_OP_DC_READ,
      prc_pkg::PRC_OP_IC_CC_INV,
      prc_pkg::PRC_OP_IC_READ,
      prc_pkg::PRC_OP_FROM_DCR,
      prc_pkg::PRC_OP_FROM_MSTATE,
      prc_pkg::PRC_OP_TO_DCR,
      prc_pkg::PRC_OP_TO_MSTATE,
      prc_pkg::PRC_OP_RET_CRIT,
      prc_pkg::PRC_OP_RET_INT,
      prc_pkg::PRC_OP_RET_MCHK,
      prc_pkg::PRC_OP_TLB_READ,
      prc_pkg::PRC_OP_TLB_SEARCH,
      prc_pkg::PRC_OP_TLB_SYNC,
      prc_pkg::PRC_OP_TLB_WRITE,
      prc_pkg::PRC_OP_EXT_EN_REG,
      prc_pkg::PRC_OP_EXT_EN_IMM: begin
        op_privileged = 1'b1; // see [RULE_09]
      end
      default: begin
        op_privileged = 1'b0;
      end
    endcase
  end

  assign user_mode = chk_req_i.problem_state_bit; // see [RULE_06] see [RULE_07]
  // bit 5 covers the reset config number too, defined or not
  assign need_priv = user_mode &&
                     (op_privileged || (spr_move && spr_bit5) || // see [RULE_10] see [RULE_12]
                      (spr_move && !spr_bit5 && spr_user_ro && !spr_is_read)); // see [RULE_11]
  assign need_illegal = user_mode && spr_move && !spr_bit5 && !spr_defined; // see [RULE_13]

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chk_rsp_o <= '0;
    end else begin
      chk_rsp_o.valid <= chk_req_i.valid;
      chk_rsp_o.priv_exc <= chk_req_i.valid && need_priv; // see [RULE_08] see [RULE_02]
      chk_rsp_o.illegal_exc <= chk_req_i.valid && need_illegal;
      chk_rsp_o.allowed <= chk_req_i.valid && !need_priv && !need_illegal;
    end
  end

  // supervisor read of the reset config number returns the image
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      spr_rdata_o <= 32'h0000_0000;
    end else if (chk_req_i.valid && spr_is_read && !user_mode &&
                 (chk_req_i.special_reg_number == SPR_RESET_CFG)) begin
      spr_rdata_o <= cfg_word; // see [RULE_01] see [RULE_02]
    end else begin
      spr_rdata_o <= 32'h0000_0000;
    end
  end

  // speculative gate: other speculation proceeds, unsafe pages wait for the committed path
  logic spec_guard_block;
  logic spec_fetch_block;

  assign spec_guard_block = spec_req_i.valid && spec_req_i.speculative &&
                            !spec_req_i.is_fetch && spec_req_i.guarded; // see [RULE_17]
  assign spec_fetch_block = spec_req_i.valid && spec_req_i.speculative &&
                            spec_req_i.is_fetch && !spec_req_i.exec_ok; // see [RULE_18]

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      spec_rsp_o <= '0;
    end else begin
      spec_rsp_o.valid <= spec_req_i.valid;
      // see [RULE_15] see [RULE_16]
      spec_rsp_o.go <= spec_req_i.valid && !spec_guard_block && !spec_fetch_block;
      spec_rsp_o.hold <= spec_guard_block || spec_fetch_block;
    end
  end

  // events, status, mask, interrupt
  logic [`PRC_EV_W-1:0] ev_set;
  logic [`PRC_EV_W-1:0] status_q;
  logic [`PRC_EV_W-1:0] mask_q;
  logic [15:0] count_q;
  logic bus_req;
  logic bus_done;
  logic rd_status;
  logic wr_mask;

  assign ev_set[`PRC_EV_PRIV] = chk_req_i.valid && need_priv;
  assign ev_set[`PRC_EV_ILLEGAL] = chk_req_i.valid && need_illegal;
  assign ev_set[`PRC_EV_GUARD] = spec_guard_block;
  assign ev_set[`PRC_EV_FETCH] = spec_fetch_block;

  assign bus_req = avs_read_i || avs_write_i;
  assign bus_done = bus_req && !avs_waitrequest_o;
  assign rd_status = bus_done && avs_read_i && (avs_address_i == `PRC_OFS_STATUS);
  assign wr_mask = bus_done && avs_write_i && (avs_address_i == `PRC_OFS_MASK) &&
                   avs_byteenable_i[0];

  // read clears, a same-cycle event still lands
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_q <= `PRC_STATUS_RST;
    end else if (rd_status) begin
      status_q <= ev_set;
    end else begin
      status_q <= status_q | ev_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mask_q <= `PRC_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= avs_writedata_i[`PRC_EV_W-1:0];
    end
  end

  // saturating count of refused user accesses
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count_q <= 16'h0000;
    end else if ((ev_set[`PRC_EV_PRIV] || ev_set[`PRC_EV_ILLEGAL]) && (count_q != 16'hffff)) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((status_q | ev_set) & mask_q);
    end
  end

  // bus answer: waitrequest drops for one cycle, one cycle after the request
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      case (avs_address_i)
        `PRC_OFS_RESET_CFG: begin
          avs_readdata_o <= cfg_word; // see [RULE_01]
        end
        `PRC_OFS_STATUS: begin
          avs_readdata_o <= {28'h0000000, status_q | ev_set};
        end
        `PRC_OFS_MASK: begin
          avs_readdata_o <= {28'h0000000, mask_q};
        end
        `PRC_OFS_COUNT: begin
          avs_readdata_o <= {16'h0000, count_q};
        end
        default: begin
          avs_readdata_o <= 32'h0000_0000;
        end
      endcase
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

endmodule

/* prc_chk_props.sv */
// Purpose: port checks of the privilege checker
// Assumes: one clock, answers one cycle after request
// Notes: bound to the design top
`timescale 1ns/1ps
`include "prc_defs.svh"

module prc_chk_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire prc_pkg::prc_chk_req_t chk_req_i,
  input wire prc_pkg::prc_chk_rsp_t chk_rsp_o,
  input wire prc_pkg::prc_spec_req_t spec_req_i,
  input wire prc_pkg::prc_spec_rsp_t spec_rsp_o,
  input wire logic [`PRC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic usr;
  logic spr_op;
  logic open_n;
  assign usr = chk_req_i.valid && chk_req_i.problem_state_bit;
  assign spr_op = chk_req_i.op inside {prc_pkg::PRC_OP_FROM_SPR, prc_pkg::PRC_OP_TO_SPR};
  assign open_n = chk_req_i.special_reg_number inside {`PRC_SPR_FXE, `PRC_SPR_LINK,
    `PRC_SPR_COUNT, `PRC_SPR_UGEN, [`PRC_SPR_UPGEN_LO:`PRC_SPR_UPGEN_HI], `PRC_SPR_TB_LO,
    `PRC_SPR_TB_HI};
  property p_one;
    chk_rsp_o.valid |-> $onehot({chk_rsp_o.allowed, chk_rsp_o.priv_exc, chk_rsp_o.illegal_exc});
  endproperty
  a_one: assert property (p_one) else $error("answer not one-hot");
  property p_sup;
    chk_req_i.valid && !chk_req_i.problem_state_bit |=> chk_rsp_o.valid && chk_rsp_o.allowed;
  endproperty
  a_sup: assert property (p_sup) else $error("supervisor refused");
  property p_plain;
    usr && chk_req_i.op == prc_pkg::PRC_OP_PLAIN |=> chk_rsp_o.valid && chk_rsp_o.allowed;
  endproperty
  a_plain: assert property (p_plain) else $error("user plain op refused");
  property p_pop;
    usr && chk_req_i.op inside {[prc_pkg::PRC_OP_DC_BLK_INV:prc_pkg::PRC_OP_EXT_EN_IMM]}
      |=> chk_rsp_o.valid && chk_rsp_o.priv_exc;
  endproperty
  a_pop: assert property (p_pop) else $error("user privileged op passed");
  property p_hi;
    usr && spr_op && chk_req_i.special_reg_number[`PRC_SPECIAL_REG_NUMBER_PRIV_BIT] |=> chk_rsp_o.priv_exc;
  endproperty
  a_hi: assert property (p_hi) else $error("number bit 5 not privileged");
  property p_open;
    usr && chk_req_i.op == prc_pkg::PRC_OP_FROM_SPR && open_n |=> chk_rsp_o.allowed;
  endproperty
  a_open: assert property (p_open) else $error("open register refused");
  property p_undef;
    usr && spr_op && !chk_req_i.special_reg_number[`PRC_SPECIAL_REG_NUMBER_PRIV_BIT] && !open_n
      |=> chk_rsp_o.illegal_exc;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined number not illegal");
  property p_hold;
    spec_req_i.valid && spec_req_i.speculative && (spec_req_i.is_fetch ? !spec_req_i.exec_ok
      : spec_req_i.guarded) |=> spec_rsp_o.valid && spec_rsp_o.hold && !spec_rsp_o.go;
  endproperty
  a_hold: assert property (p_hold) else $error("unsafe let go");
  property p_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_rsv;
    avs_read_i && !avs_waitrequest_o && avs_address_i == `PRC_OFS_RESET_CFG
      |-> (avs_readdata_o & 32'hffff_0f70) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved cfg bit set");
endmodule

bind prc_privilege_check prc_chk_props u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .chk_req_i(chk_req_i), .chk_rsp_o(chk_rsp_o), .spec_req_i(spec_req_i),
  .spec_rsp_o(spec_rsp_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o));

/* prc_dec_model.sv */
// Purpose: decode and dispatch side of the checker
// Assumes: one request per call, answer the edge after
// Notes: idle requests carry valid low
`timescale 1ns/1ps

module prc_dec_model (
  input wire logic mclk_i,
  output prc_pkg::prc_chk_req_t chk_req_o,
  input wire prc_pkg::prc_chk_rsp_t chk_rsp_i,
  output prc_pkg::prc_spec_req_t spec_req_o,
  input wire prc_pkg::prc_spec_rsp_t spec_rsp_i
);
  initial begin
    chk_req_o = '0;
    spec_req_o = '0;
  end
  // supervisor callers keep to defined numbers
  task automatic issue(input prc_pkg::prc_chk_req_t r, output prc_pkg::prc_chk_rsp_t a);
    @(posedge mclk_i);
    chk_req_o <= r;
    @(posedge mclk_i);
    chk_req_o <= '0;
    #1 a = chk_rsp_i;
  endtask
  task automatic spec(input prc_pkg::prc_spec_req_t r, output prc_pkg::prc_spec_rsp_t a);
    @(posedge mclk_i);
    spec_req_o <= r;
    @(posedge mclk_i);
    spec_req_o <= '0;
    #1 a = spec_rsp_i;
  endtask
endmodule

/* tb.sv */
// Purpose: self-checking bench of the privilege checker
// Assumes: straps held from reset on
// Notes: answer codes are {allowed, priv, illegal}
`timescale 1ns/1ps
`include "prc_defs.svh"

module tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] s_attr = 4'ha;
  logic s_le = 1'b1;
  logic [3:0] s_extended_real_page = 4'h5;
  logic [31:0] cfg_exp;
  prc_pkg::prc_chk_req_t chk_req;
  prc_pkg::prc_chk_rsp_t chk_rsp;
  prc_pkg::prc_spec_req_t spec_req;
  prc_pkg::prc_spec_rsp_t spec_rsp;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] spr_rd;
  logic wait_rq;
  logic irq;
  int miscompares = 0;
  int n_compared = 0;
  assign cfg_exp = {16'h0, s_attr, 4'h0, s_le, 3'h0, s_extended_real_page};
  always #10 mclk_i = ~mclk_i;

  prc_privilege_check uut (.mclk_i(mclk_i), .rst_i(rst_i), .strap_user_attr_i(s_attr),
    .strap_little_endian_i(s_le), .strap_extended_real_page_i(s_extended_real_page), .chk_req_i(chk_req),
    .chk_rsp_o(chk_rsp), .spr_rdata_o(spr_rd), .spec_req_i(spec_req), .spec_rsp_o(spec_rsp),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq), .irq_o(irq));
  prc_dec_model u_dec (.mclk_i(mclk_i), .chk_req_o(chk_req), .chk_rsp_i(chk_rsp),
    .spec_req_o(spec_req), .spec_rsp_i(spec_rsp));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge mclk_i);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wait_rq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    check("bus answer", 32'h0, {31'h0, wait_rq});
  endtask
  task automatic req(input string what, input logic pr, input prc_pkg::prc_op_t op,
                     input logic [9:0] n, input logic [2:0] exp);
    prc_pkg::prc_chk_rsp_t a;
    u_dec.issue({1'b1, pr, op, n}, a);
    check(what, {28'h0, 1'b1, exp}, {28'h0, a});
  endtask
  task automatic t_cfg();
    logic [31:0] q;
    bus(1'b0, `PRC_OFS_RESET_CFG, 32'h0, q);
    check("cfg", cfg_exp, q);
    bus(1'b1, `PRC_OFS_RESET_CFG, 32'hffff_ffff, q);
    bus(1'b0, `PRC_OFS_RESET_CFG, 32'h0, q);
    check("cfg after write", cfg_exp, q);
    bus(1'b0, 8'h40, 32'h0, q);
    check("unmapped", 32'h0, q);
    req("cfg sup", 1'b0, prc_pkg::PRC_OP_FROM_SPR, `PRC_SPR_RESET_CFG, 3'h4);
    check("cfg spr", cfg_exp, spr_rd);
    req("cfg user", 1'b1, prc_pkg::PRC_OP_FROM_SPR, `PRC_SPR_RESET_CFG, 3'h2);
    $display("t_cfg done");
  endtask
  task automatic t_ops();
    for (int i = 0; i <= 18; i++) begin
      req("op user", 1'b1, prc_pkg::prc_op_t'(i), 10'h0, i == 0 ? 3'h4 : 3'h2);
      req("op sup", 1'b0, prc_pkg::prc_op_t'(i), 10'h0, 3'h4);
    end
    $display("t_ops done");
  endtask
  task automatic t_spr();
    logic [13:0] tab [13] = '{{1'b0, `PRC_SPR_FXE, 3'h4}, {1'b1, `PRC_SPR_FXE, 3'h4},
      {1'b0, `PRC_SPR_LINK, 3'h4}, {1'b1, `PRC_SPR_COUNT, 3'h4}, {1'b1, `PRC_SPR_UGEN, 3'h4},
      {1'b0, `PRC_SPR_UPGEN_LO, 3'h4}, {1'b1, `PRC_SPR_UPGEN_HI, 3'h2},
      {1'b0, `PRC_SPR_TB_LO, 3'h4}, {1'b1, `PRC_SPR_TB_HI, 3'h2}, {1'b0, 10'h010, 3'h2},
      {1'b1, 10'h3f0, 3'h2}, {1'b0, 10'h002, 3'h1}, {1'b1, 10'h20f, 3'h1}};
    for (int i = 0; i < 13; i++) begin
      req("spr user", 1'b1, tab[i][13] ? prc_pkg::PRC_OP_TO_SPR : prc_pkg::PRC_OP_FROM_SPR,
        tab[i][12:3], tab[i][2:0]);
    end
    $display("t_spr done");
  endtask
  task automatic t_spec();
    prc_pkg::prc_spec_rsp_t a;
    logic h;
    for (int i = 0; i < 16; i++) begin
      h = i[2] && (i[3] ? !i[0] : i[1]);
      u_dec.spec({1'b1, i[3:0]}, a);
      check("spec", {29'h0, 1'b1, !h, h}, {29'h0, a});
    end
    $display("t_spec done");
  endtask
  task automatic t_irq();
    logic [31:0] q;
    bus(1'b0, `PRC_OFS_STATUS, 32'h0, q);
    // priv, illegal, guarded hold and fetch hold all seen by the earlier tests
    check("status all", 32'hf, q);
    bus(1'b1, `PRC_OFS_MASK, 32'h1, q);
    bus(1'b0, `PRC_OFS_MASK, 32'h0, q);
    check("mask", 32'h1, q);
    req("irq op", 1'b1, prc_pkg::PRC_OP_TO_MSTATE, 10'h0, 3'h2);
    repeat (2) @(posedge mclk_i);
    #1 check("irq up", 32'h1, {31'h0, irq});
    bus(1'b0, `PRC_OFS_STATUS, 32'h0, q);
    check("status", 32'h1, q);
    repeat (2) @(posedge mclk_i);
    #1 check("irq down", 32'h0, {31'h0, irq});
    bus(1'b1, `PRC_OFS_MASK, 32'h0, q);
    req("irq ill", 1'b1, prc_pkg::PRC_OP_FROM_SPR, 10'h002, 3'h1);
    repeat (2) @(posedge mclk_i);
    #1 check("irq masked", 32'h0, {31'h0, irq});
    bus(1'b0, `PRC_OFS_STATUS, 32'h0, q);
    check("status ill", 32'h2, q);
    // refused user requests: 1 cfg, 18 ops, 6 spr, 2 irq
    bus(1'b0, `PRC_OFS_COUNT, 32'h0, q);
    check("count", 32'h1b, q);
    $display("t_irq done");
  endtask
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    t_cfg();
    t_ops();
    t_spr();
    t_spec();
    t_irq();
    close_out();
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
